/* File: rtl/ppwm_pkg.sv */
// Shared constants for the push-pull PWM generator
package ppwm_pkg;
   localparam int unsigned CNT_W        = 16;
   localparam int unsigned MODE_HI      = 11;
   localparam int unsigned MODE_LO      = 10;
   localparam int unsigned IMMEDIATE_PERIOD_UPDATE_BIT     = 10;
   localparam int unsigned DIV_HI       = 15;
   localparam int unsigned DIV_LO       = 12;
   localparam int unsigned STRT_W       = 6;
   localparam int unsigned DIV_W        = 4;
   localparam int unsigned DT_W         = 8;
   localparam logic [1:0]  MODE_COMP    = 2'h0;
   localparam logic [1:0]  MODE_REDUND  = 2'h1;
   localparam logic [1:0]  MODE_PUSHPL  = 2'h2;
   localparam logic [1:0]  MODE_INDEP   = 2'h3;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
   localparam logic [DIV_W-1:0] DIV_ZERO = 4'h0;
   localparam logic [DIV_W-1:0] DIV_ONE  = 4'h1;
   localparam logic [STRT_W-1:0] STRT_ZERO = 6'h00;
   localparam logic [STRT_W-1:0] STRT_ONE  = 6'h01;
   localparam logic [DT_W-1:0]  DT_ZERO  = 8'h00;
   localparam logic [DT_W-1:0]  DT_ONE   = 8'h01;
endpackage : ppwm_pkg

/* File: rtl/ppwm_trig.sv */
// Trigger divider and postscaler start for the compare trigger
`timescale 1ns/100ps
module ppwm_trig
   import ppwm_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              run,
   input  wire logic              match,
   input  wire logic              cycle_start,
   input  wire logic [DIV_W-1:0]  divider,
   input  wire logic [STRT_W-1:0] start_sel,
   output logic                   trig_out
);
   typedef struct packed {
      logic [DIV_W-1:0]  div_cnt;
      logic [STRT_W-1:0] strt_cnt;
      logic              armed;
      logic              trig;
   } ppwm_trig_st_t;

   ppwm_trig_st_t st_r;
   ppwm_trig_st_t st_nxt;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.trig = 1'b0;
      if (!run) begin
         st_nxt.div_cnt  = DIV_ZERO;
         st_nxt.strt_cnt = STRT_ZERO;
         st_nxt.armed    = (start_sel == STRT_ZERO);
      end else begin
         // Start delay counts whole cycles before the divider is armed
         if (!st_r.armed && cycle_start) begin
            if (st_r.strt_cnt + STRT_ONE >= start_sel) begin
               st_nxt.armed = 1'b1;
            end
            st_nxt.strt_cnt = st_r.strt_cnt + STRT_ONE;
         end
         // First armed match always fires; a compare of zero misses the match at the cycle start that arms
         if (st_r.armed && match) begin
            if (st_r.div_cnt == DIV_ZERO) begin
               st_nxt.trig = 1'b1;
            end
            if (st_r.div_cnt >= divider) begin
               st_nxt.div_cnt = DIV_ZERO;
            end else begin
               st_nxt.div_cnt = st_r.div_cnt + DIV_ONE;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign trig_out = st_r.trig;
endmodule : ppwm_trig

/* File: rtl/ppwm_gen.sv */
// Push-pull PWM generator with phase, dead time, swap and triggers
`timescale 1ns/100ps
module ppwm_gen
   import ppwm_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              module_master_enable,
   input  wire logic [15:0]       primary_time_base_control,
   input  wire logic [15:0]       output_pin_control,
   input  wire logic [15:0]       trigger_control,
   input  wire logic [STRT_W-1:0] trigger_postscale_start,
   input  wire logic [CNT_W-1:0]  period_value,
   input  wire logic              period_write,
   input  wire logic [CNT_W-1:0]  duty_value,
   input  wire logic [CNT_W-1:0]  phase_shift_value,
   input  wire logic [CNT_W-1:0]  primary_trigger_compare,
   input  wire logic [CNT_W-1:0]  special_event_compare,
   input  wire logic [DT_W-1:0]   dead_time,
   input  wire logic              swap_enable,
   output logic                   high_side_output,
   output logic                   low_side_output,
   output logic                   trigger_out,
   output logic                   pwm_irq,
   output logic [CNT_W-1:0]       time_base
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] per_act;
      logic [CNT_W-1:0] per_pend;
      logic             pend;
      logic             pp_sel;
      logic             pp_last;
      logic             pp_pulsed;
      logic             hi_want;
      logic             lo_want;
      logic [DT_W-1:0]  dt_cnt;
      logic             hi_out;
      logic             lo_out;
      logic             irq;
   } ppwm_gen_st_t;

   ppwm_gen_st_t st_r;
   ppwm_gen_st_t st_nxt;

   logic [1:0]       mode;
   logic             immediate_period_update;
   logic             run;
   logic             wrap;
   logic             cyc_start;
   logic             trig_match;
   logic             sev_match;
   logic [CNT_W-1:0] pwm_val;
   logic             raw;
   logic             center;

   // Center-aligned complementary: pulse sits symmetric about mid-count
   function automatic logic duty_on(input logic [CNT_W-1:0] c,
                                    input logic [CNT_W-1:0] p,
                                    input logic [CNT_W-1:0] d,
                                    input logic             ctr);
      logic [CNT_W:0] half;
      half = {1'b0, (p >> 1)};
      if (ctr) begin
         duty_on = ({1'b0, c} + {1'b0, (d >> 1)} >= half) &&
                   ({1'b0, c} < half + {1'b0, (d >> 1)});
      end else begin
         duty_on = (c < d);
      end
   endfunction : duty_on

   assign mode   = output_pin_control[MODE_HI:MODE_LO];
   assign immediate_period_update   = primary_time_base_control[IMMEDIATE_PERIOD_UPDATE_BIT];
   assign run    = module_master_enable;
   assign center = (mode == MODE_COMP);
   // At-or-above so a period cut below the count still wraps
   assign wrap   = run && (st_r.cnt >= st_r.per_act);
   assign cyc_start  = run && (st_r.cnt == CNT_ZERO);
   assign trig_match = run && (st_r.cnt == primary_trigger_compare);
   assign sev_match  = run && (st_r.cnt == special_event_compare);
   assign pwm_val    = st_r.cnt;
   assign raw = duty_on(pwm_val, st_r.per_act, duty_value, center);

   always_comb begin
      st_nxt       = st_r;
      // Either compare raises the same one-cycle request
      st_nxt.irq   = sev_match || trig_match;
      if (!run) begin
         // Outputs parked low and time base reloaded with phase offset
         st_nxt.cnt       = phase_shift_value;
         st_nxt.hi_out    = 1'b0;
         st_nxt.lo_out    = 1'b0;
         st_nxt.hi_want   = 1'b0;
         st_nxt.lo_want   = 1'b0;
         st_nxt.dt_cnt    = DT_ZERO;
         st_nxt.pp_sel    = 1'b0;
         st_nxt.pp_last   = 1'b1;
         st_nxt.pp_pulsed = 1'b0;
         st_nxt.irq       = 1'b0;
         if (period_write) begin
            st_nxt.per_act = period_value;
            st_nxt.pend    = 1'b0;
         end
      end else begin
         if (wrap) begin
            st_nxt.cnt = CNT_ZERO;
         end else begin
            st_nxt.cnt = st_r.cnt + CNT_ONE;
         end
         // Period takes effect; only the period moves, pin steering is
         // owned by the cycle boundary, so a write at rollover cannot
         // retrigger the same pin
         if (period_write && immediate_period_update) begin
            st_nxt.per_act = period_value;
            st_nxt.pend    = 1'b0;
         end else if (period_write) begin
            st_nxt.per_pend = period_value;
            st_nxt.pend     = 1'b1;
         end
         if (wrap && !immediate_period_update && (st_r.pend || period_write)) begin
            st_nxt.per_act = period_write ? period_value
                                          : st_r.per_pend;
            st_nxt.pend    = 1'b0;
         end
         // Push-pull: switch pin only if the last cycle really pulsed
         if (wrap) begin
            if (st_r.pp_pulsed) begin
               st_nxt.pp_last = st_r.pp_sel;
               st_nxt.pp_sel  = ~st_r.pp_sel;
            end
            st_nxt.pp_pulsed = 1'b0;
         end else if (raw && (st_r.pp_sel != st_r.pp_last)) begin
            st_nxt.pp_pulsed = 1'b1;
         end
         case (mode)
            MODE_PUSHPL: begin
               // Same pin as the previous pulse is held off
               st_nxt.hi_want = raw && !wrap && !st_r.pp_sel &&
                                (st_r.pp_last != st_r.pp_sel);
               st_nxt.lo_want = raw && !wrap && st_r.pp_sel &&
                                (st_r.pp_last != st_r.pp_sel);
            end
            MODE_REDUND: begin
               st_nxt.hi_want = raw;
               st_nxt.lo_want = raw;
            end
            MODE_INDEP: begin
               st_nxt.hi_want = raw;
               st_nxt.lo_want = 1'b0;
            end
            default: begin
               st_nxt.hi_want = raw;
               st_nxt.lo_want = !raw;
            end
         endcase
         if (swap_enable) begin
            // Both taken before either is overwritten
            {st_nxt.hi_want, st_nxt.lo_want} = {st_nxt.lo_want,
                                                st_nxt.hi_want};
         end
         // Dead time, complementary mode only: a rising edge waits until both are low long enough;
         // swap toggles just look like ordinary edges here
         if (mode == MODE_COMP) begin
            if (!st_nxt.hi_want) begin
               st_nxt.hi_out = 1'b0;
            end
            if (!st_nxt.lo_want) begin
               st_nxt.lo_out = 1'b0;
            end
            if (st_nxt.hi_out || st_nxt.lo_out) begin
               st_nxt.dt_cnt = DT_ZERO;
            end else if (st_r.dt_cnt < dead_time) begin
               st_nxt.dt_cnt = st_r.dt_cnt + DT_ONE;
            end else if (st_nxt.hi_want && !st_nxt.lo_want) begin
               st_nxt.hi_out = 1'b1;
            end else if (st_nxt.lo_want && !st_nxt.hi_want) begin
               st_nxt.lo_out = 1'b1;
            end
         end else begin
            st_nxt.hi_out = st_nxt.hi_want;
            st_nxt.lo_out = st_nxt.lo_want;
            st_nxt.dt_cnt = DT_ZERO;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_r <= '{pp_last: 1'b1, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   ppwm_trig u_trig (
      .core_clk    (core_clk),
      .rst_n       (rst_n),
      .run         (run),
      .match       (trig_match),
      .cycle_start (cyc_start),
      .divider     (trigger_control[DIV_HI:DIV_LO]),
      .start_sel   (trigger_postscale_start),
      .trig_out    (trigger_out)
   );

   assign high_side_output = st_r.hi_out;
   assign low_side_output  = st_r.lo_out;
   assign pwm_irq          = st_r.irq;
   assign time_base        = st_r.cnt;
endmodule : ppwm_gen

/* File: verification/ppwm_gen_sva.sv */
// Concurrent checks on the generator ports
`timescale 1ns/100ps
module ppwm_gen_sva
   import ppwm_pkg::*;
(
   input wire logic              core_clk,
   input wire logic              rst_n,
   input wire logic              module_master_enable,
   input wire logic [15:0]       output_pin_control,
   input wire logic [15:0]       trigger_control,
   input wire logic [STRT_W-1:0] trigger_postscale_start,
   input wire logic [CNT_W-1:0]  primary_trigger_compare,
   input wire logic [CNT_W-1:0]  special_event_compare,
   input wire logic [DT_W-1:0]   dead_time,
   input wire logic              swap_enable,
   input wire logic              high_side_output,
   input wire logic              low_side_output,
   input wire logic              trigger_out,
   input wire logic              pwm_irq,
   input wire logic [CNT_W-1:0]  time_base
);
   logic       en;
   logic [1:0] md;
   logic       hi_last_r;
   logic [7:0] gap_r;
   assign en = module_master_enable;
   assign md = output_pin_control[MODE_HI:MODE_LO];
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Cleared while idle, since the first pulse belongs on the high pin
   always_ff @(posedge core_clk)
      if (!rst_n || !en) hi_last_r <= 1'b0;
      else if (high_side_output ^ low_side_output)
         hi_last_r <= high_side_output;
   // Saturates so a long idle never wraps back to a short gap
   always_ff @(posedge core_clk)
      if (!rst_n || high_side_output || low_side_output) gap_r <= 8'h00;
      else if (gap_r != 8'hFF) gap_r <= gap_r + 8'h01;
   sequence s_trig_hit;
      en && trigger_control[DIV_HI:DIV_LO] == DIV_ZERO &&
      trigger_postscale_start == STRT_ZERO &&
      time_base == primary_trigger_compare ##1 en;
   endsequence
   sequence s_sev_hit;
      en && time_base == special_event_compare ##1 en;
   endsequence
   sequence s_cmp_hit;
      en && time_base == primary_trigger_compare ##1 en;
   endsequence
   a_trig_on_match: assert property (s_trig_hit |-> trigger_out)
      else $error("trigger missing after compare match");
   a_trig_has_cause: assert property (trigger_out |->
      $past(time_base) == $past(primary_trigger_compare))
      else $error("trigger without compare match");
   a_irq_on_event: assert property (s_sev_hit |-> pwm_irq)
      else $error("interrupt missing after event match");
   a_irq_on_trig: assert property (s_cmp_hit |-> pwm_irq)
      else $error("interrupt missing after trigger compare");
   a_irq_has_cause: assert property (pwm_irq |->
      $past(time_base) == $past(special_event_compare) ||
      $past(time_base) == $past(primary_trigger_compare))
      else $error("interrupt without compare match");
   a_idle_quiet: assert property (!en |=>
      !(high_side_output || low_side_output || trigger_out || pwm_irq))
      else $error("activity while disabled");
   a_pp_alternate: assert property (md == MODE_PUSHPL &&
      ($rose(high_side_output) || $rose(low_side_output))
      |-> hi_last_r == low_side_output)
      else $error("push-pull pulse repeated on one pin");
   a_dead_gap: assert property (md == MODE_COMP &&
      ($rose(high_side_output) || $rose(low_side_output))
      |-> gap_r >= dead_time) else $error("dead time too short");
   a_indep_low_off: assert property (md == MODE_INDEP &&
      !swap_enable |=> !low_side_output) else $error("low pin driven");
   a_swap_high_off: assert property (md == MODE_INDEP &&
      swap_enable |=> !high_side_output) else $error("swap not applied");
endmodule : ppwm_gen_sva

/* File: verification/ppwm_stage.sv */
// Power stage model counting gate pulses on each side
`timescale 1ns/100ps
module ppwm_stage (
   input  wire logic   core_clk,
   input  wire logic   gate_hi,
   input  wire logic   gate_lo,
   output logic [15:0] hi_pulses,
   output logic [15:0] lo_pulses
);
   logic hi_d;
   logic lo_d;
   initial {hi_pulses, lo_pulses} = 32'h0000_0000;
   always @(posedge core_clk) begin
      if (gate_hi && !hi_d) hi_pulses <= hi_pulses + 16'h0001;
      if (gate_lo && !lo_d) lo_pulses <= lo_pulses + 16'h0001;
      hi_d <= gate_hi;
      lo_d <= gate_lo;
   end
endmodule : ppwm_stage

/* File: verification/ppwm_gen_tb.sv */
// Self-checking bench for the push-pull PWM generator
`timescale 1ns/100ps
module ppwm_gen_tb
   import ppwm_pkg::*;
;
   logic              core_clk, rst_n, en, pw, swp, hi, lo, tro, irq;
   logic [15:0]       ptc, opc, tgc, per, duty, phase, trg, sev, tb;
   logic [15:0]       hp, lp, ptb, v, ex, h0, l0;
   logic [STRT_W-1:0] strt;
   logic [DT_W-1:0]   dt;
   logic [15:0]       tq[$];
   logic [15:0]       pq[$];
   int                fails, compares, cyc_n, d, k;
   ppwm_gen i_dut (.core_clk, .rst_n, .module_master_enable(en),
      .primary_time_base_control(ptc), .output_pin_control(opc),
      .trigger_control(tgc), .trigger_postscale_start(strt),
      .period_value(per), .period_write(pw), .duty_value(duty),
      .phase_shift_value(phase), .primary_trigger_compare(trg),
      .special_event_compare(sev), .dead_time(dt), .swap_enable(swp),
      .high_side_output(hi), .low_side_output(lo), .trigger_out(tro),
      .pwm_irq(irq), .time_base(tb));
   ppwm_stage i_stage (.core_clk, .gate_hi(hi), .gate_lo(lo),
      .hi_pulses(hp), .lo_pulses(lp));
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task wt(input logic [15:0] x);
      for (int i = 0; i < 300 && tb !== x; i++) @(negedge core_clk);
      chk("awaited base", x, tb);
   endtask : wt
   task wr(input logic [15:0] x);
      per = x;
      pw = 1'b1;
      @(negedge core_clk);
      pw = 1'b0;
   endtask : wr
   // Mode changes only while stopped; swap is set here while stopped but cleared later mid-run
   task cfg(input logic [1:0] md, input logic [15:0] p, input logic s);
      en = 1'b0;
      @(negedge core_clk);
      opc = {4'h0, md, 10'h000};
      swp = s;
      wr(p);
      en = 1'b1;
   endtask : cfg
   task summarize;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc_n++;
      if (cyc_n == 3000) begin
         fails++;
         summarize();
      end
   end
   // Sampled after the edge, once registered outputs have settled
   always begin
      @(posedge core_clk);
      #1;
      if (tro === 1'b1) begin
         ex = (tq.size() > 0) ? tq.pop_front() : 16'hFFFF;
         chk("trigger base", ex, ptb);
      end
      if (en && tb < ptb && pq.size() > 0) begin
         ex = pq.pop_front();
         chk("period peak", ex, ptb);
      end
      ptb = tb;
   end
   initial begin
      {ptc, opc, tgc, per, duty, phase, sev} = 112'h0;
      {strt, dt, rst_n, en, pw, swp} = 18'h0;
      trg = 16'hFFFF;
      void'($urandom(91378));
      repeat (5) @(negedge core_clk);
      rst_n = 1'b1;
      {phase, duty, sev} = {16'h0005, 16'h0004, 16'h0007};
      repeat (3) @(negedge core_clk);
      chk("idle base", phase, tb);
      chk("idle pins", 16'h0000, {12'h000, hi, lo, tro, irq});
      cfg(MODE_PUSHPL, 16'h0014, 1'b0);
      wt(16'h000A);
      wr(16'h000C);
      pq = '{16'h0014, 16'h000C, 16'h000C};
      repeat (45) @(negedge core_clk);
      chk("peaks left", 16'h0000, 16'(pq.size()));
      ptc[IMMEDIATE_PERIOD_UPDATE_BIT] = 1'b1;
      wt(16'h0005);
      wr(16'h001E);
      pq.push_back(16'h001E);
      wt(16'h001E);
      v = 16'($urandom_range(40, 10));
      wr(v);
      pq.push_back(v);
      repeat (100) @(negedge core_clk);
      chk("peaks left", 16'h0000, 16'(pq.size()));
      chk("pulse balance", 16'h0000, (hp - lp) & 16'hFFFE);
      phase = 16'h0000;
      // Last pass: start select two arms on the second cycle start
      for (d = 0; d < 4; d++) begin
         k = (d == 3) ? 0 : (1 << d) - 1;
         en = 1'b0;
         repeat (2) @(negedge core_clk);
         tgc = {4'(k), 12'h000};
         strt = (d == 3) ? 6'h02 : STRT_ZERO;
         trg = (d == 0) ? 16'($urandom_range(14, 8)) : 16'h0003;
         repeat ((d == 3) ? 2 : 3) tq.push_back(trg);
         cfg(MODE_PUSHPL, 16'h000F, 1'b0);
         repeat (48 * k + 50) @(negedge core_clk);
         en = 1'b0;
         repeat (2) @(negedge core_clk);
         chk("triggers left", 16'h0000, 16'(tq.size()));
      end
      {trg, strt} = {16'hFFFF, STRT_ZERO};
      {dt, duty} = {8'h03, 16'h0006};
      for (d = 0; d < 4; d++) begin
         cfg(2'(d), 16'h0014, 1'(d != 2));
         {h0, l0} = {hp, lp};
         repeat (30) @(negedge core_clk);
         if (d == 1 || d == 3) begin
            // Six-count duty from count zero: two pulses in thirty cycles
            chk("high pulses", (d == 1) ? 16'h0002 : 16'h0000, hp - h0);
            chk("low pulses", 16'h0002, lp - l0);
         end
         swp = 1'b0;
         repeat (30) @(negedge core_clk);
      end
      summarize();
   end
endmodule : ppwm_gen_tb
bind ppwm_gen ppwm_gen_sva i_sva (.core_clk, .rst_n, .module_master_enable,
   .output_pin_control, .trigger_control, .trigger_postscale_start,
   .primary_trigger_compare, .special_event_compare, .dead_time,
   .swap_enable, .high_side_output, .low_side_output, .trigger_out,
   .pwm_irq, .time_base);
